//--- design/slwb_cfg.svh
`ifndef SLWB_CFG_SVH
`define SLWB_CFG_SVH

// Register file size and reset contents.
`define SLWB_NUM_REGS 25
`define SLWB_REG_RST 8'h00
`define SLWB_REGCTL_IDX 0
`define SLWB_LED_EN_BIT 6

// Device address decoding.
`define SLWB_GEN_CALL 8'h00
`define SLWB_ADDR_HI 2'h0
`define SLWB_STRAP_NOWR 6'h3F

// Byte framing on the serial link.
`define SLWB_BIT_LAST 3'h7
`define SLWB_BIT_ONE 3'h1

// Timing of the forwarded link, in ns and in system clock cycles.
`define SLWB_CLK_NS 40
`define SLWB_LEAD_NS 10
`define SLWB_END_NS 40
`define SLWB_LEAD_CYC ((`SLWB_LEAD_NS + `SLWB_CLK_NS - 1) / `SLWB_CLK_NS)
`define SLWB_END_CYC ((`SLWB_END_NS + `SLWB_CLK_NS - 1) / `SLWB_CLK_NS)

`endif

//--- design/slwb_pkg.sv
package slwb_pkg;

    // Position inside a frame, Gray coded along address, register, data.
    typedef enum logic [1:0] {
        SLWB_DEV  = 2'b00,
        SLWB_REG  = 2'b01,
        SLWB_DATA = 2'b11,
        SLWB_SKIP = 2'b10
    } slwb_phase_t;

    // One register write travelling from the link domain.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } slwb_wr_t;

    // Levels sampled into the system clock domain.
    typedef struct packed {
        logic lclk;
        logic ldata;
        logic cs_n;
        logic mode;
        logic short_flt;
        logic hot;
        logic pend_tog;
        logic cmt_tog;
        logic start_tog;
    } slwb_smp_t;

endpackage

//--- design/slwb_bridge.sv
`timescale 1ns/1ps
`include "slwb_cfg.svh"

// The block is split into two clock domains. The link domain runs on the
// incoming serial clock and does all bit, byte and frame decoding, because
// the host may stop that clock between frames and the decoder must still
// see every edge it does give. The system domain runs on the free-running
// clock and owns the setting registers, the LED gate and the forwarded pair.
// Only toggles and a word that stays still for a whole byte time cross from
// the link domain into the system domain, so no multi-bit value is ever
// caught halfway through a change.
// The forwarded pair is rebuilt from resampled levels instead of being a
// plain gate of the input pins. This costs a few system cycles of delay but
// gives edges and a data lead time that do not depend on the sender's skew.
module slwb_bridge import slwb_pkg::*; #(
    parameter int NUM_REGS = `SLWB_NUM_REGS
) (
    // System clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic undervoltage_lockout_i,
    // Serial link input pins.
    input wire logic link_clk_i,
    input wire logic link_data_i,
    input wire logic chip_select_n_i,
    input wire logic mode_i,
    input wire logic [5:0] address_strap_pins_i,
    // Protection inputs.
    input wire logic current_set_short_i,
    input wire logic over_temp_i,
    // Forwarded differential link.
    output logic fwd_clk_o,
    output logic fwd_data_o,
    output logic fwd_oe_n_o,
    // Register contents and LED gating.
    output logic led_enable_o,
    output logic [NUM_REGS*8-1:0] setting_registers_o
);

    // Detects a rising level between two samples.
    function automatic logic rose(input logic now_v, input logic old_v);
        return now_v & ~old_v;
    endfunction

    // Undervoltage acts as a reset of both domains.
    wire logic arst_n;
    assign arst_n = rst_n_i & ~undervoltage_lockout_i;

    // ---------------- Link clock domain ----------------

    // Everything in this domain is reset by the same combined reset as the
    // system side. The decoder therefore forgets a half-received frame when
    // the supply dips, and the first frame afterwards may be lost while the
    // strap and mode synchronisers catch up. A host that cannot afford that
    // loss sends a short filler frame first, which is exactly what the
    // documented link initialisation does.
    // The synchronisers only advance on serial clock edges, so a strap or
    // mode change is seen two serial clock edges after it happens.
    logic [7:0] l_sync1;
    logic [7:0] l_sync2;
    wire logic l_mode;
    wire logic l_ce;
    wire logic [5:0] l_strap;
    logic cs_idle;
    logic d_neg;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    slwb_phase_t phase;
    logic [7:0] reg_addr;
    logic pend_l;
    slwb_wr_t pend_word;
    logic pend_tog;
    logic cmt_tog;
    logic start_tog;

    // Straps and mode cross into the link domain; reset to the no-write strap.
    always_ff @(posedge link_clk_i or negedge arst_n) begin
        if (!arst_n) begin
            l_sync1 <= {1'b1, 1'b1, `SLWB_STRAP_NOWR};
            l_sync2 <= {1'b1, 1'b1, `SLWB_STRAP_NOWR};
        end else begin
            l_sync1 <= {mode_i, ce_i, address_strap_pins_i};
            l_sync2 <= l_sync1;
        end
    end

    assign l_mode = l_sync2[7];
    assign l_ce = l_sync2[6];
    assign l_strap = l_sync2[5:0];

    // Own address and the address match for the first byte.
    wire logic [7:0] own_addr;
    wire logic no_write;
    wire logic [7:0] byte_in;
    wire logic addr_hit;
    assign own_addr = {`SLWB_ADDR_HI, l_strap};
    assign no_write = (l_strap == `SLWB_STRAP_NOWR);
    assign byte_in = {shreg[6:0], link_data_i};
    assign addr_hit = !no_write && ((byte_in == own_addr) ||
                      (byte_in == `SLWB_GEN_CALL));

    // In three-wire mode the frame start is known from the select pin alone.
    // The flag below is set asynchronously by a high select level, so it is
    // already set when the first serial clock edge of the next frame comes.
    // A synchronous detector would need clock edges while select is high,
    // and many hosts give none. In differential mode the select input has no
    // meaning and the flag only matters while the mode synchroniser still
    // holds its reset value, where it makes every edge look like a start.
    // The set term is a combination of a pin and a synchronised level; it
    // can only glitch while the mode changes, when frames are not expected.
    // Select high sets this flag at once, since the serial clock may stand still
    // while deselected; the first edge with select low then opens the frame.
    wire logic cs_idle_set;
    assign cs_idle_set = ~arst_n | (chip_select_n_i & l_mode);

    always_ff @(posedge link_clk_i or posedge cs_idle_set) begin
        if (cs_idle_set) begin
            cs_idle <= 1'b1;
        end else if (l_ce) begin
            cs_idle <= 1'b0;
        end
    end

    // Data seen at the falling clock edge; low after a high bit marks a start.
    always_ff @(negedge link_clk_i or negedge arst_n) begin
        if (!arst_n) begin
            d_neg <= 1'b1;
        end else if (l_ce) begin
            d_neg <= link_data_i;
        end
    end

    wire logic hdr_seen;
    wire logic frame_start;
    wire logic byte_done;
    assign hdr_seen = shreg[0] & ~d_neg;
    assign frame_start = l_mode ? cs_idle : hdr_seen;
    assign byte_done = (bit_cnt == `SLWB_BIT_LAST);

    // The bit counter starts at one on a frame start because the start edge
    // itself already shifts in the first bit of the address byte. A byte is
    // complete when the counter reads seven before the edge, so the shifted
    // value on that edge, not the register, holds the finished byte.
    // A frame whose address does not match falls into the skip phase and
    // stays there until the next start, so stray bytes never reach the
    // register address or the pending word. The skip phase is also the reset
    // phase, so nothing is written before the first start after reset.
    // Bit and byte framing on the rising serial clock edge.
    always_ff @(posedge link_clk_i or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            phase <= SLWB_SKIP;
            start_tog <= 1'b0;
        end else if (l_ce) begin
            shreg <= byte_in;
            if (frame_start) begin
                bit_cnt <= `SLWB_BIT_ONE;
                phase <= SLWB_DEV;
                start_tog <= ~start_tog;
            end else begin
                bit_cnt <= 3'(bit_cnt + 3'h1);
                if (byte_done) begin
                    unique case (phase)
                        SLWB_DEV: phase <= addr_hit ? SLWB_REG : SLWB_SKIP;
                        SLWB_REG: phase <= SLWB_DATA;
                        SLWB_DATA: phase <= SLWB_DATA;
                        SLWB_SKIP: phase <= SLWB_SKIP;
                    endcase
                end
            end
        end
    end

    // Data bytes wait as pending; the next clock edge commits them, a start drops them.
    always_ff @(posedge link_clk_i or negedge arst_n) begin
        if (!arst_n) begin
            reg_addr <= 8'h00;
            pend_l <= 1'b0;
            pend_word <= '0;
            pend_tog <= 1'b0;
            cmt_tog <= 1'b0;
        end else if (l_ce) begin
            if (frame_start) begin
                pend_l <= 1'b0;
            end else if (byte_done && phase == SLWB_REG) begin
                reg_addr <= byte_in;
            end else if (byte_done && phase == SLWB_DATA) begin
                pend_word <= '{addr: reg_addr, data: byte_in};
                reg_addr <= 8'(reg_addr + 8'h01);
                pend_l <= 1'b1;
                pend_tog <= ~pend_tog;
            end else if (pend_l) begin
                pend_l <= 1'b0;
                cmt_tog <= ~cmt_tog;
            end
        end
    end

    // ---------------- System clock domain ----------------

    slwb_smp_t s_raw;
    slwb_smp_t s_sync1;
    slwb_smp_t s_sync2;
    slwb_smp_t s_prev;

    assign s_raw = '{lclk: link_clk_i, ldata: link_data_i, cs_n: chip_select_n_i,
                     mode: mode_i, short_flt: current_set_short_i, hot: over_temp_i,
                     pend_tog: pend_tog, cmt_tog: cmt_tog, start_tog: start_tog};

    // All link and protection pins and link-domain toggles pass two flip-flops before any system-domain logic
    // reads them; the third stage is only history for the edge detectors.
    // The select and mode history reset to their idle high levels, so the
    // release of reset never looks like a select fall or a mode change.
    // The serial clock is sampled here as a level. This limits the serial
    // clock to a period of a few system cycles, which is the trade made for
    // regenerating clean edges on the forwarded pair.
    // Two-stage synchroniser plus one history stage for edge detection.
    always_ff @(posedge sys_clk_i or negedge arst_n) begin
        if (!arst_n) begin
            s_sync1 <= '{cs_n: 1'b1, mode: 1'b1, default: 1'b0};
            s_sync2 <= '{cs_n: 1'b1, mode: 1'b1, default: 1'b0};
            s_prev <= '{cs_n: 1'b1, mode: 1'b1, default: 1'b0};
        end else if (ce_i) begin
            s_sync1 <= s_raw;
            s_sync2 <= s_sync1;
            s_prev <= s_sync2;
        end
    end

    // Events decoded from the synchronised levels.
    wire logic ev_pend;
    wire logic ev_cmt;
    wire logic ev_start;
    wire logic wire3;
    wire logic cs_fall;
    wire logic cs_rise;
    wire logic lclk_rise;
    wire logic hdr_in;
    assign ev_pend = s_sync2.pend_tog ^ s_prev.pend_tog;
    assign ev_cmt = s_sync2.cmt_tog ^ s_prev.cmt_tog;
    assign ev_start = s_sync2.start_tog ^ s_prev.start_tog;
    assign wire3 = s_sync2.mode;
    assign cs_fall = wire3 & rose(s_prev.cs_n, s_sync2.cs_n);
    assign cs_rise = wire3 & rose(s_sync2.cs_n, s_prev.cs_n);
    assign lclk_rise = rose(s_sync2.lclk, s_prev.lclk) & (~wire3 | ~s_sync2.cs_n);
    assign hdr_in = ~wire3 & s_prev.ldata & ~s_sync2.ldata & s_sync2.lclk & s_prev.lclk;

    // Pending write copied from the link; its word is stable for a whole byte time.
    logic p_valid;
    slwb_wr_t p_word;
    logic [NUM_REGS-1:0][7:0] setting_q;

    wire logic do_commit;
    wire logic in_range;
    assign do_commit = p_valid & (ev_cmt | cs_rise);
    assign in_range = (p_word.addr < 8'(NUM_REGS));

    always_ff @(posedge sys_clk_i or negedge arst_n) begin
        if (!arst_n) begin
            p_valid <= 1'b0;
            p_word <= '0;
        end else if (ce_i) begin
            if (ev_pend) begin
                p_valid <= 1'b1;
                p_word <= pend_word;
            end else if (ev_start | do_commit) begin
                p_valid <= 1'b0;
            end
        end
    end

    // A write lands only once the pending word has been confirmed by the
    // following serial clock edge or by select rising. A frame start that
    // arrives first drops the pending word instead. Addresses past the last
    // register are dropped here rather than wrapping onto a low register,
    // since a wrapped write would silently corrupt brightness settings.
    // There is no read path; software only sees the effect on the LEDs.
    // The setting registers; lost only through reset or undervoltage.
    always_ff @(posedge sys_clk_i or negedge arst_n) begin
        if (!arst_n) begin
            setting_q <= {NUM_REGS{`SLWB_REG_RST}};
        end else if (ce_i && do_commit && in_range) begin
            setting_q[p_word.addr[4:0]] <= p_word.data;
        end
    end

    assign setting_registers_o = setting_q;

    // Faults gate the LED enable and release it as soon as they clear.
    always_ff @(posedge sys_clk_i or negedge arst_n) begin
        if (!arst_n) begin
            led_enable_o <= 1'b0;
        end else if (ce_i) begin
            led_enable_o <= setting_q[`SLWB_REGCTL_IDX][`SLWB_LED_EN_BIT]
                            & ~s_sync2.short_flt
                            & ~s_sync2.hot;
        end
    end

    // The forwarded pair is floated while in reset and driven from the first
    // system clock edge after it. Select edges take priority over clock
    // edges, since both select edges must produce their marker or end pulse
    // even when a clock edge is seen in the same system cycle.
    // The counter below holds the output clock low; both the lead time and
    // the end pulse round up to one system cycle at the nominal clock rate.
    // Forwarded link: the clock drops with the new data and rises after a lead
    // time, so data bits change while the output clock is low; only start markers drop data with the clock high. The output
    // is resampled at the system rate, which costs a fixed latency of a few
    // cycles but regenerates clean edges.
    localparam logic [3:0] LEAD_CYC = 4'(`SLWB_LEAD_CYC);
    localparam logic [3:0] END_CYC = 4'(`SLWB_END_CYC);
    logic [3:0] hi_cnt;

    always_ff @(posedge sys_clk_i or negedge arst_n) begin
        if (!arst_n) begin
            fwd_clk_o <= 1'b1;
            fwd_data_o <= 1'b1;
            fwd_oe_n_o <= 1'b1;
            hi_cnt <= 4'h0;
        end else if (ce_i) begin
            fwd_oe_n_o <= 1'b0;
            if (cs_fall) begin
                fwd_data_o <= 1'b0;
            end else if (cs_rise) begin
                fwd_data_o <= 1'b1;
                fwd_clk_o <= 1'b0;
                hi_cnt <= END_CYC;
            end else if (lclk_rise) begin
                fwd_data_o <= s_sync2.ldata;
                fwd_clk_o <= 1'b0;
                hi_cnt <= LEAD_CYC;
            end else if (hdr_in) begin
                fwd_data_o <= 1'b0;
            end else if (hi_cnt != 4'h0) begin
                hi_cnt <= 4'(hi_cnt - 4'h1);
                fwd_clk_o <= (hi_cnt == 4'h1);
            end
        end
    end

    // Note for integrators: the clock enable also freezes the link domain,
    // but only after two serial clock edges, so a frame already under way
    // when the enable falls may still change the link-side state slightly.
    // Keep the enable high for the whole of any frame that must be received.

endmodule

//--- test/slwb_bridge_properties.sv
`timescale 1ns/1ps
`include "slwb_cfg.svh"
// Port-level checks of the bridge; all of them run on the system clock.
module slwb_bridge_properties #(
    parameter int NUM_REGS = 25
) (
    // Clock, reset and control inputs.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic undervoltage_lockout_i,
    input wire logic chip_select_n_i,
    input wire logic mode_i,
    input wire logic [5:0] address_strap_pins_i,
    input wire logic current_set_short_i,
    input wire logic over_temp_i,
    // Observed outputs.
    input wire logic fwd_clk_o,
    input wire logic fwd_data_o,
    input wire logic fwd_oe_n_o,
    input wire logic led_enable_o,
    input wire logic [NUM_REGS*8-1:0] setting_registers_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_lockout_float: assert property (
        undervoltage_lockout_i |-> fwd_oe_n_o && fwd_clk_o && fwd_data_o)
        else $error("forwarded pair not floated in lockout");
    a_lockout_clear: assert property (
        undervoltage_lockout_i |-> setting_registers_o == '0 && !led_enable_o)
        else $error("registers or led enable kept in lockout");
    // The pair must leave the floating state once both resets are gone.
    a_pair_driven: assert property (
        ce_i && $past(ce_i) && $past(rst_n_i) && !undervoltage_lockout_i
        && !$past(undervoltage_lockout_i) |-> !fwd_oe_n_o)
        else $error("forwarded pair still floating");
    // Six cycles leave room for the level synchroniser in front of the gate.
    a_short_dark: assert property (current_set_short_i [*6] |-> !led_enable_o)
        else $error("led enable high during resistor short");
    a_hot_dark: assert property (over_temp_i [*6] |-> !led_enable_o)
        else $error("led enable high during over temperature");
    a_select_marker: assert property (
        mode_i && $fell(chip_select_n_i) |-> ##[1:6] (fwd_clk_o && !fwd_data_o))
        else $error("no start marker after select fall");
    a_select_end: assert property (
        mode_i && $rose(chip_select_n_i) |-> ##[1:6] (fwd_data_o && !fwd_clk_o))
        else $error("no end pulse with data high after select rise");
    a_clock_pulse: assert property ($fell(fwd_clk_o) |=> fwd_clk_o)
        else $error("forwarded clock low longer than one cycle");
    a_data_lead: assert property ($rose(fwd_clk_o) |-> $stable(fwd_data_o))
        else $error("forwarded data moved with clock rise");
    a_nowrite_hold: assert property (
        address_strap_pins_i == `SLWB_STRAP_NOWR && !undervoltage_lockout_i
        |=> $stable(setting_registers_o))
        else $error("register written with all straps high");
endmodule

bind slwb_bridge slwb_bridge_properties #(.NUM_REGS(NUM_REGS)) slwb_bridge_properties_inst (
    .sys_clk_i, .rst_n_i, .ce_i, .undervoltage_lockout_i, .chip_select_n_i, .mode_i,
    .address_strap_pins_i, .current_set_short_i, .over_temp_i, .fwd_clk_o, .fwd_data_o,
    .fwd_oe_n_o, .led_enable_o, .setting_registers_o);

//--- test/slwb_host_model.sv
`timescale 1ns/1ps
// Behavioural host sending frames at a 125 ns bit period; its clock stops between frames.
module slwb_host_model (
    // Link pins towards the device.
    output logic link_clk_o,
    output logic link_data_o,
    output logic chip_select_n_o
);
    localparam realtime HALF = 62.5;
    initial begin
        link_clk_o = 1'h0;
        link_data_o = 1'h1;
        chip_select_n_o = 1'h1;
    end
    // Data moves a quarter period after the fall, well clear of either edge.
    task automatic put_bit(input logic b);
        #(HALF / 2) link_data_o = b;
        #(HALF / 2) link_clk_o = 1'h1;
        #(HALF) link_clk_o = 1'h0;
    endtask
    // Whole bytes MSB first; stray bits model an aborted byte.
    task automatic send_bits(input logic [7:0] q [$], input int stray);
        foreach (q[i]) for (int k = 7; k >= 0; k--) put_bit(q[i][k]);
        for (int k = 0; k < stray; k++) put_bit(k[0]);
    endtask
    task automatic frame_3w(input logic [7:0] q [$], input int stray);
        chip_select_n_o = 1'h0;
        send_bits(q, stray);
        #(HALF) chip_select_n_o = 1'h1;
        link_data_o = ~link_data_o; // Unselected data shows no stale level.
        #(4 * HALF);
    endtask
    // The long high phase keeps the marker apart from the repeated clock edge.
    task automatic frame_diff(input logic [7:0] q [$], input int stray);
        link_clk_o = 1'h0;
        #(HALF / 2) link_data_o = 1'h1;
        #(HALF / 2) link_clk_o = 1'h1;
        #(2 * HALF) link_data_o = 1'h0;
        #(2 * HALF) link_clk_o = 1'h0;
        send_bits(q, stray);
        if (stray == 0) begin
            #(HALF / 2) link_data_o = 1'h1;
            #(HALF / 2) link_clk_o = 1'h1;
        end
        #(4 * HALF);
    endtask
endmodule

//--- test/slwb_bridge_tb.sv
`timescale 1ns/1ps
module slwb_bridge_tb;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic undervoltage_lockout = 1'h0;
    logic mode = 1'h1;
    logic [5:0] strap = 6'h05;
    logic short_flt = 1'h0;
    logic hot = 1'h0;
    logic ce = 1'h1;
    wire lclk, ldata, cs_n, fclk, fdata, foe_n, led;
    wire [199:0] regs;
    logic [7:0] exp_r [25];
    int mismatches = 0;
    int cmp_count = 0;

    // System clock at 25 MHz.
    always #20 sys_clk = ~sys_clk;

    slwb_host_model slwb_host_model_inst (.link_clk_o(lclk), .link_data_o(ldata),
        .chip_select_n_o(cs_n));
    slwb_bridge slwb_bridge_inst (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .ce_i(ce),
        .undervoltage_lockout_i(undervoltage_lockout), .link_clk_i(lclk), .link_data_i(ldata),
        .chip_select_n_i(cs_n), .mode_i(mode), .address_strap_pins_i(strap),
        .current_set_short_i(short_flt), .over_temp_i(hot), .fwd_clk_o(fclk),
        .fwd_data_o(fdata), .fwd_oe_n_o(foe_n), .led_enable_o(led),
        .setting_registers_o(regs));

    task automatic check(input string what, input logic [199:0] seen, input logic [199:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Outputs are read on the falling edge, after the rising edge has settled.
    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic check_regs();
        logic [199:0] e;
        settle(10);
        for (int i = 0; i < 25; i++) e[8*i +: 8] = exp_r[i];
        check("registers", regs, e);
    endtask
    // Sends a frame; hit says whether this device must take its data bytes.
    task automatic frame(input logic [7:0] q [$], input int stray, input logic hit);
        if (mode) slwb_host_model_inst.frame_3w(q, stray);
        else slwb_host_model_inst.frame_diff(q, stray);
        if (hit) for (int i = 2; i < q.size(); i++) exp_r[q[1] + i - 2] = q[i];
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic t_reset();
        settle(16);
        check("idle outputs", {fclk, fdata, foe_n, led}, 4'hE);
        check("reset registers", regs, '0);
        @(posedge sys_clk) rst_n <= 1'h1;
        settle(6);
        check("pair enable", foe_n, 1'h0);
    endtask
    // The first frame only brings the link-side synchronisers up to date.
    task automatic t_write_3w();
        frame({8'h2A}, 0, 1'h0);
        frame({8'h05, 8'h00, 8'h40, 8'hAA, 8'hBB}, 0, 1'h1);
        check_regs();
        check("led enable", led, 1'h1);
    endtask
    task automatic t_decode();
        frame({8'h00, 8'h03, 8'h5A}, 0, 1'h1);
        frame({8'h06, 8'h04, 8'h77}, 0, 1'h0);
        check_regs();
        frame({8'h05, 8'h05, 8'h11}, 4, 1'h1);
        frame({8'h05, 8'h06, 8'h22}, 0, 1'h1);
        check_regs();
    endtask
    task automatic t_no_write();
        @(posedge sys_clk) strap <= 6'h3F;
        frame({8'h00, 8'h0A, 8'h99}, 0, 1'h0);
        frame({8'h3F, 8'h0B, 8'h98}, 0, 1'h0);
        check_regs();
        @(posedge sys_clk) strap <= 6'h05;
    endtask
    task automatic t_faults();
        @(posedge sys_clk) short_flt <= 1'h1;
        settle(8);
        check("led in short", led, 1'h0);
        @(posedge sys_clk) short_flt <= 1'h0;
        hot <= 1'h1;
        settle(8);
        check("led when hot", led, 1'h0);
        @(posedge sys_clk) hot <= 1'h0;
        settle(8);
        check("led resumed", led, 1'h1);
    endtask
    // A mode change reaches the link domain only after two serial clock edges, so a filler frame goes first.
    task automatic t_diff();
        @(posedge sys_clk) mode <= 1'h0;
        frame({8'h2A}, 0, 1'h0);
        frame({8'h05, 8'h07, 8'hC3}, 0, 1'h1);
        check_regs();
        frame({8'h05, 8'h08, 8'hE1}, 3, 1'h1);
        frame({8'h00, 8'h0A, 8'h3C}, 0, 1'h1);
        check_regs();
    endtask
    task automatic t_lockout();
        @(posedge sys_clk) undervoltage_lockout <= 1'h1;
        settle(3);
        check("lockout outputs", {fclk, fdata, foe_n, led}, 4'hE);
        check("lockout registers", regs, '0);
        @(posedge sys_clk) undervoltage_lockout <= 1'h0;
        foreach (exp_r[i]) exp_r[i] = 8'h00;
        frame({8'h2A}, 0, 1'h0);
        frame({8'h05, 8'h0C, 8'h5F}, 0, 1'h1);
        check_regs();
    endtask

    // Cuts a hung run short and reports it as a mismatch.
    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        $display("unexpected run length: expected end, seen timeout");
        conclude();
    end
    initial begin
        foreach (exp_r[i]) exp_r[i] = 8'h00;
        t_reset();
        t_write_3w();
        t_decode();
        t_no_write();
        t_faults();
        t_diff();
        t_lockout();
        conclude();
    end
endmodule
